// ### hdl/vme_master_map.svh
// Constants of the VMEbus master interface: modifier codes, limits, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef VME_MASTER_MAP_SVH
`define VME_MASTER_MAP_SVH
`define AM_A24_BASE 6'h38
`define AM_A32_BASE 6'h08
`define AM_SPACE_MASK 6'h38
`define AM_SUP_OFS 6'h04
`define AM_T_MBLT 6'h00
`define AM_T_DATA 6'h01
`define AM_T_PROG 6'h02
`define AM_T_BLT 6'h03
`define AM_A16_SUP 6'h2D
`define AM_A16_NP 6'h29
`define AM_CRCSR 6'h2F
`define AM_LCK_A16 6'h2C
`define AM_LCK_A24 6'h32
`define AM_LCK_A32 6'h05
`define UAM_RST 6'h10
`define UAM_HI_MASK 6'h30
`define UAM_HI 6'h10
`define BLT_MAX 12'h100
`define MBLT_MAX 12'h800
`define LVL_DEF 2'h3
`define PACK_LO_BE 8'h0F
`define PACK_HI_BE 8'hF0
`endif

// ### hdl/vme_master_pkg.sv
// Types shared by the VMEbus master interface.
// Assumes nothing of its surroundings.
package vme_master_pkg;
    typedef enum logic [1:0] {SP_A16, SP_A24, SP_A32, SP_CR} space_t;
    typedef enum logic [1:0] {W8, W16, W32, W64} width_t;
    typedef enum logic [1:0] {OWN_TGT, OWN_DMA, OWN_IRQ, OWN_LOCK} own_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ  = 3'h1,
        ST_ADDR = 3'h3,
        ST_DATA = 3'h2,
        ST_GAP  = 3'h6,
        ST_PACK = 3'h4
    } fsm_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic [7:0]  be;
        space_t      space;
        logic        sup;
        logic        prog;
        logic        blk;
        logic        mblt;
        width_t      max_vme_data_width;
        logic        pci64;
        logic        write;
        logic        posted;
        logic        more;
        logic        iack;
        logic [1:0]  user;
    } req_t;
    typedef struct packed {
        logic       valid;
        logic       multi;
        logic       iack;
        logic [5:0] am;
    } err_t;
    typedef struct packed {
        fsm_t            st;
        own_t            own;
        logic            rr;
        logic            pk;
        logic            tk;
        req_t            cur;
        logic [7:0]      rem;
        logic [7:0]      chk;
        logic [63:0]     acc;
        logic [11:0]     ten;
        logic [11:0]     blk;
        logic            bbsy;
        logic            breq;
        logic [1:0]      lvl;
        logic            as;
        logic [7:0]      ds;
        logic            wr;
        logic            iack;
        logic [5:0]      am;
        logic [31:0]     addr;
        logic [63:0]     dout;
        logic            done;
        logic [3:0]      take;
        logic            abort;
        logic            purge;
        logic [63:0]     rdata;
        logic            irqv;
        logic            irqp;
        logic [1:0][5:0] uc;
        err_t            elog;
        logic [31:0]     eaddr;
    } regs_t;
endpackage

// ### hdl/vme_master_interface.sv
// VMEbus master interface: turns channel beats into VMEbus cycles.
// Assumes one clock, channels hold a beat until take_o, bus grant from requester.
`timescale 1ns/1ps
`default_nettype none
`include "vme_master_map.svh"
// Behaviour
// - Master only after arbitration and bus grant
// - Address space and type from image
// - Overlap next address except on MBLT
// - A24 modifier codes 0x3F..0x38
// - A32 modifier codes 0xF..0x8
// - Lock cycles only from special generator
// - Two user codes 0x10..0x1F, reset 0x10
// - Split wide beat; block when enabled
// - Unpack writes, pack reads to PCI width
// - Equal width full beat: one cycle
// - No packing narrower, except 32-to-64 write bursts
// - Only aligned cycles, ordered by enables
// - Block cycles per image, length follows PCI
// - Posted tenure count minimum, hold bit extends
// - DMA blocks 256/2K, limited by tenure
// - Only DTACK or BERR end cycles
// - Coupled BERR: target abort, no log
// - Posted/IACK BERR: log code, purge
// - Multiple error flag, valid flag, address
// - Posted BERR interrupts per two enables
// - DTACK means cycle completed
// - Interrupt channel first, then lock, target and DMA fair
// - One request level, default level 3
module vme_master_interface
    import vme_master_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        tgt_valid_i,
    input  wire req_t        tgt_req_i,
    input  wire logic        dma_valid_i,
    input  wire req_t        dma_req_i,
    input  wire logic        irq_valid_i,
    input  wire req_t        irq_req_i,
    input  wire logic        lock_valid_i,
    input  wire req_t        lock_req_i,
    output logic [3:0]       take_o,
    output logic             done_o,
    output logic [63:0]      rdata_o,
    output logic             abort_o,
    output logic             purge_o,
    input  wire logic [1:0]  req_level_i,
    input  wire logic        bus_grant_i,
    output logic             bus_req_o,
    output logic [1:0]       bus_level_o,
    output logic             bus_busy_o,
    input  wire logic [11:0] posted_tenure_byte_count_i,
    input  wire logic        sw_bus_hold_bit_i,
    input  wire logic [11:0] dma_tenure_counter_i,
    output logic             as_o,
    output logic [7:0]       ds_o,
    output logic             write_o,
    output logic             iack_o,
    output logic [5:0]       am_o,
    output logic [31:0]      addr_o,
    output logic [63:0]      dout_o,
    input  wire logic        dtack_i,
    input  wire logic        berr_i,
    input  wire logic [63:0] din_i,
    input  wire logic [1:0]  user_modifier_codes_we_i,
    input  wire logic [5:0]  user_modifier_codes_wdata_i,
    output logic [1:0][5:0]  user_modifier_codes_o,
    input  wire logic        err_clear_i,
    output err_t             vme_error_modifier_log_o,
    output logic [31:0]      vme_error_address_log_o,
    input  wire logic        vme_side_error_irq_enable_i,
    input  wire logic        pci_side_error_irq_enable_i,
    output logic             irq_vme_o,
    output logic             irq_pci_o
);
    regs_t       q;
    regs_t       d;
    req_t [3:0]  rq;
    logic [3:0]  avail;
    own_t        pick;
    logic        pick_ok;
    logic        keep;
    own_t        o;
    req_t        nr;
    logic        have;
    logic        pack_ok;
    width_t      ew;
    logic [7:0]  c;
    logic [3:0]  n;
    logic [11:0] lim;

    function automatic logic [3:0] wb_f(input width_t w);
        return 4'(1 << w);
    endfunction

    function automatic logic [2:0] lo_f(input logic [7:0] m);
        logic [2:0] r;
        r = '0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) r = 3'(i);
        end
        return r;
    endfunction

    function automatic logic [3:0] cnt_f(input logic [7:0] m);
        logic [3:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) r = r + 4'(m[i]);
        return r;
    endfunction

    // Largest aligned, fully enabled piece at the lowest enabled lane
    function automatic logic [7:0] chunk_f(input logic [7:0] be, input logic [3:0] mx);
        logic [7:0] m;
        logic [7:0] k;
        logic [2:0] i;
        int         s;
        m = '0;
        i = lo_f(be);
        for (int j = 0; j < 4; j++) begin
            s = 1 << j;
            k = 8'(((9'(1) << s) - 9'(1)) << i);
            if (s <= int'(mx) && (int'(i) % s) == 0 && (be & k) == k && be != '0) m = k;
        end
        return m;
    endfunction

    function automatic logic [63:0] lanes_f(input logic [7:0] m);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) r[i*8 +: 8] = {8{m[i]}};
        return r;
    endfunction

    function automatic logic [5:0] am_f(input req_t r, input logic [1:0][5:0] uc,
                                        input logic lk);
        logic [5:0] t;
        logic [5:0] a;
        t = r.blk ? (r.mblt ? `AM_T_MBLT : `AM_T_BLT) : (r.prog ? `AM_T_PROG : `AM_T_DATA);
        if (r.sup) t = t + `AM_SUP_OFS;
        case (r.space)
            SP_A16: a = lk ? `AM_LCK_A16 : (r.sup ? `AM_A16_SUP : `AM_A16_NP);
            SP_A24: a = lk ? `AM_LCK_A24 : `AM_A24_BASE + t;
            SP_A32: a = lk ? `AM_LCK_A32 : `AM_A32_BASE + t;
            default: a = `AM_CRCSR;
        endcase
        if (r.user != '0 && !lk) a = uc[r.user[1]];
        return a;
    endfunction

    assign rq    = {lock_req_i, irq_req_i, dma_req_i, tgt_req_i};
    assign avail = {lock_valid_i, irq_valid_i, dma_valid_i, tgt_valid_i} & ~q.take;

    always_comb begin
        pick    = OWN_TGT;
        pick_ok = 1'b1;
        if (avail[OWN_IRQ]) pick = OWN_IRQ;
        else if (avail[OWN_LOCK]) pick = OWN_LOCK;
        else if (avail[OWN_TGT] && avail[OWN_DMA]) pick = q.rr ? OWN_DMA : OWN_TGT;
        else if (avail[OWN_TGT]) pick = OWN_TGT;
        else if (avail[OWN_DMA] && !sw_bus_hold_bit_i) pick = OWN_DMA;
        else pick_ok = 1'b0;
        case (q.own)
            OWN_TGT: keep = q.ten < posted_tenure_byte_count_i || sw_bus_hold_bit_i;
            OWN_DMA: keep = q.ten < dma_tenure_counter_i;
            default: keep = 1'b0;
        endcase
        keep    = keep && q.bbsy && avail[q.own];
        o       = keep ? q.own : pick;
        nr      = rq[o];
        have    = q.bbsy && (o == q.own || sw_bus_hold_bit_i);
        pack_ok = !nr.pci64 && nr.max_vme_data_width == W64 && nr.more && nr.write
                  && nr.be == `PACK_LO_BE;
        ew      = q.cur.max_vme_data_width;
        if (!q.cur.pci64 && ew == W64 && !q.pk) ew = W32;
        c       = chunk_f(q.rem, wb_f(ew));
        n       = cnt_f(q.chk);
        lim     = q.cur.mblt ? `MBLT_MAX : `BLT_MAX;
    end

    always_comb begin
        d       = q;
        d.done  = 1'b0;
        d.take  = '0;
        d.abort = 1'b0;
        d.purge = 1'b0;
        d.irqv  = 1'b0;
        d.irqp  = 1'b0;
        d.lvl   = req_level_i;
        for (int k = 0; k < 2; k++) begin
            if (user_modifier_codes_we_i[k] && (user_modifier_codes_wdata_i & `UAM_HI_MASK) == `UAM_HI)
                d.uc[k] = user_modifier_codes_wdata_i;
        end
        if (err_clear_i) d.elog = '0;
        case (q.st)
            ST_IDLE: begin
                if (keep || pick_ok) begin
                    d.own = o;
                    d.cur = nr;
                    d.rem = nr.be;
                    d.acc = '0;
                    d.pk  = 1'b0;
                    d.tk  = 1'b0;
                    d.rr  = (o == OWN_TGT);
                    if (o != q.own || !q.bbsy) d.ten = '0;
                    if (!(q.as && o == q.own && nr.blk)) begin
                        d.as  = 1'b0;
                        d.blk = '0;
                    end
                    d.bbsy = have;
                    if (pack_ok) begin
                        d.take = 4'(1) << o;
                        d.tk   = 1'b1;
                        d.st   = ST_PACK;
                    end else begin
                        d.breq = !have;
                        d.st   = have ? ST_ADDR : ST_REQ;
                    end
                end else begin
                    d.as   = 1'b0;
                    d.bbsy = q.bbsy && sw_bus_hold_bit_i;
                end
            end
            ST_PACK: begin
                if (avail[q.own]) begin
                    if (rq[q.own].addr[31:3] == q.cur.addr[31:3]
                        && rq[q.own].be == `PACK_HI_BE) begin
                        d.cur.data[63:32] = rq[q.own].data[63:32];
                        d.cur.more        = rq[q.own].more;
                        d.rem             = q.rem | rq[q.own].be;
                        d.pk              = 1'b1;
                    end
                    d.breq = !q.bbsy;
                    d.st   = q.bbsy ? ST_ADDR : ST_REQ;
                end
            end
            ST_REQ: begin
                d.breq = 1'b1;
                if (bus_grant_i) begin
                    d.breq = 1'b0;
                    d.bbsy = 1'b1;
                    d.st   = ST_ADDR;
                end
            end
            ST_ADDR: begin
                d.chk  = c;
                d.addr = {q.cur.addr[31:3], lo_f(c)};
                d.am   = am_f(q.cur, q.uc, q.own == OWN_LOCK);
                d.as   = 1'b1;
                d.wr   = q.cur.write && q.own != OWN_LOCK;
                d.iack = q.cur.iack;
                d.dout = q.cur.data;
                d.ds   = (q.own == OWN_LOCK) ? '0 : c;
                d.st   = ST_DATA;
            end
            ST_DATA: begin
                if (berr_i) begin
                    d.ds    = '0;
                    d.as    = 1'b0;
                    d.rem   = '0;
                    d.blk   = '0;
                    d.done  = 1'b1;
                    d.take  = (q.tk && !q.pk) ? 4'h0 : 4'(1) << q.own;
                    d.rdata = q.acc;
                    d.st    = ST_IDLE;
                    if (q.own == OWN_DMA && !sw_bus_hold_bit_i) d.bbsy = 1'b0;
                    if (q.own == OWN_TGT && !q.cur.posted && !q.cur.iack)
                        d.abort = 1'b1;
                    else if ((q.cur.posted && q.cur.write) || q.cur.iack) begin
                        d.purge = 1'b1;
                        if (q.elog.valid && !err_clear_i) d.elog.multi = 1'b1;
                        else begin
                            d.elog.valid = 1'b1;
                            d.elog.am    = q.am;
                            d.elog.iack  = q.iack;
                            d.eaddr      = q.addr;
                        end
                        d.irqv = q.cur.posted && vme_side_error_irq_enable_i;
                        d.irqp = q.cur.posted && pci_side_error_irq_enable_i;
                    end
                end else if (dtack_i) begin
                    d.ds  = '0;
                    d.acc = q.acc | (din_i & lanes_f(q.chk));
                    d.rem = q.rem & ~q.chk;
                    d.ten = 12'(q.ten + 12'(n));
                    d.blk = 12'(q.blk + 12'(n));
                    if (d.rem != '0) begin
                        if (q.cur.blk && q.cur.mblt) begin
                            d.as = 1'b0;
                            d.st = ST_GAP;
                        end else begin
                            d.as   = q.cur.blk;
                            d.addr = {q.cur.addr[31:3], lo_f(chunk_f(d.rem, wb_f(ew)))};
                            d.st   = ST_ADDR;
                        end
                    end else begin
                        d.done  = 1'b1;
                        d.take  = (q.tk && !q.pk) ? 4'h0 : 4'(1) << q.own;
                        d.rdata = d.acc;
                        if (!(q.cur.blk && q.cur.more && d.blk < lim)) begin
                            d.as  = 1'b0;
                            d.blk = '0;
                        end
                        d.st = ST_IDLE;
                    end
                end
            end
            ST_GAP: d.st = ST_ADDR;
            default: d.st = ST_IDLE;
        endcase
        if (rst_i) begin
            d       = '0;
            d.lvl   = `LVL_DEF;
            d.uc[0] = `UAM_RST;
            d.uc[1] = `UAM_RST;
        end
    end

    always_ff @(posedge mclk_i) begin
        q <= d;
    end

    assign take_o                   = q.take;
    assign done_o                   = q.done;
    assign rdata_o                  = q.rdata;
    assign abort_o                  = q.abort;
    assign purge_o                  = q.purge;
    assign bus_req_o                = q.breq;
    assign bus_level_o              = q.lvl;
    assign bus_busy_o               = q.bbsy;
    assign as_o                     = q.as;
    assign ds_o                     = q.ds;
    assign write_o                  = q.wr;
    assign iack_o                   = q.iack;
    assign am_o                     = q.am;
    assign addr_o                   = q.addr;
    assign dout_o                   = q.dout;
    assign user_modifier_codes_o    = q.uc;
    assign vme_error_modifier_log_o = q.elog;
    assign vme_error_address_log_o  = q.eaddr;
    assign irq_vme_o                = q.irqv;
    assign irq_pci_o                = q.irqp;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence gap_s;
        !as_o ##1 !as_o ##1 as_o;
    endsequence
    sequence berr_posted_s;
        q.st == ST_DATA && berr_i && q.cur.posted && q.cur.write;
    endsequence

    bus_owned_a: assert property (as_o |-> bus_busy_o)
        else $error("Address strobe without bus ownership");
    am_a24_a: assert property ($rose(as_o) && q.cur.space == SP_A24 && q.own != OWN_LOCK
        && q.cur.user == 2'h0 |-> (am_o & `AM_SPACE_MASK) == `AM_A24_BASE
        && ((am_o & `AM_SUP_OFS) != '0) == q.cur.sup)
        else $error("Wrong A24 modifier");
    am_a32_a: assert property ($rose(as_o) && q.cur.space == SP_A32 && q.own != OWN_LOCK
        && q.cur.user == 2'h0 |-> (am_o & `AM_SPACE_MASK) == `AM_A32_BASE)
        else $error("Wrong A32 modifier");
    lock_no_data_a: assert property (as_o && q.own == OWN_LOCK |-> ds_o == '0)
        else $error("Lock cycle drove data strobes");
    user_range_a: assert property ((user_modifier_codes_o[0] & `UAM_HI_MASK) == `UAM_HI
        && (user_modifier_codes_o[1] & `UAM_HI_MASK) == `UAM_HI)
        else $error("User modifier out of range");
    mblt_gap_a: assert property (q.st == ST_GAP |-> gap_s)
        else $error("Block 64 cycle pipelined address");
    lanes_in_beat_a: assert property (as_o |-> (ds_o & ~q.rem) == '0)
        else $error("Data strobe outside enabled lanes");
    abort_nolog_a: assert property (abort_o && !$past(err_clear_i)
        |-> $stable(vme_error_modifier_log_o))
        else $error("Coupled error changed the log");
    posted_err_a: assert property (berr_posted_s |=> purge_o && vme_error_modifier_log_o.valid
        && irq_vme_o == $past(vme_side_error_irq_enable_i)
        && irq_pci_o == $past(pci_side_error_irq_enable_i))
        else $error("Posted write error not handled");
    multi_err_a: assert property ((berr_posted_s and (q.elog.valid && !err_clear_i))
        |=> vme_error_modifier_log_o.multi)
        else $error("Multiple error flag not set");
    dtack_done_a: assert property (q.st == ST_DATA && dtack_i && !berr_i && q.rem == q.chk
        |=> done_o && !abort_o)
        else $error("Acknowledge did not complete beat");
    irq_first_a: assert property (q.st == ST_IDLE && !q.bbsy && avail[OWN_IRQ]
        |=> q.own == OWN_IRQ)
        else $error("Interrupt channel not served first");
endmodule // vme_master_interface
`default_nettype wire

// ### dv/vme_slave_model.sv
// Behavioural VMEbus slave facing the master interface.
// Assumes registered master strobes and the one system clock.
`timescale 1ns/1ps
`default_nettype none
module vme_slave_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        as_i,
    input  wire logic [7:0]  ds_i,
    input  wire logic        addr_only_i,
    input  wire logic        fail_i,
    input  wire logic [1:0]  wait_i,
    input  wire logic [63:0] rdata_i,
    output logic             dtack_o,
    output logic             berr_o,
    output logic [63:0]      din_o
);
    logic [1:0] cnt_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dtack_o <= 1'b0;
            berr_o  <= 1'b0;
            cnt_q   <= 2'h0;
            din_o   <= 64'h5555_5555_5555_5555;
        end else if (!as_i || (ds_i == 8'h00 && !addr_only_i) || dtack_o || berr_o) begin
            dtack_o <= 1'b0;
            berr_o  <= 1'b0;
            cnt_q   <= wait_i;
            din_o   <= ~din_o; // Released lines toggle
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            din_o <= ~din_o;
        end else begin
            dtack_o <= !fail_i;
            berr_o  <= fail_i;
            din_o   <= rdata_i;
        end
    end
endmodule // vme_slave_model
`default_nettype wire

// ### dv/tb_vme_master_interface.sv
// Self-checking bench of the VMEbus master interface.
// Assumes the slave model on the far side and a grant that follows the request.
`timescale 1ns/1ps
`default_nettype none
module tb_vme_master_interface;
    import vme_master_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, bus_grant_i, dtack_i, berr_i, fail, err_clear_i;
    logic tgt_valid_i, dma_valid_i, irq_valid_i, lock_valid_i, bus_req_o, bus_busy_o;
    logic sw_bus_hold_bit_i, vme_side_error_irq_enable_i, pci_side_error_irq_enable_i;
    logic done_o, abort_o, purge_o, as_o, write_o, iack_o, irq_vme_o, irq_pci_o;
    logic [1:0] req_level_i, bus_level_o, user_modifier_codes_we_i, wt;
    logic [3:0] take_o;
    logic [5:0] am_o, user_modifier_codes_wdata_i;
    logic [7:0] ds_o;
    logic [11:0] posted_tenure_byte_count_i, dma_tenure_counter_i;
    logic [31:0] addr_o, vme_error_address_log_o;
    logic [63:0] rdata_o, dout_o, din_i, mdata;
    logic [1:0][5:0] user_modifier_codes_o;
    err_t vme_error_modifier_log_o;
    req_t beat;
    logic [77:0] pq[$];
    logic [7:0] expq[$];
    int failures = 0, checked = 0, n_ab = 0, n_pu = 0, n_iv = 0, n_ip = 0;
    always #2.5 mclk_i = ~mclk_i;
    vme_master_interface uut (
        .mclk_i, .rst_i, .tgt_valid_i, .tgt_req_i(beat), .dma_valid_i, .dma_req_i(beat),
        .irq_valid_i, .irq_req_i(beat), .lock_valid_i, .lock_req_i(beat), .take_o, .done_o,
        .rdata_o, .abort_o, .purge_o, .req_level_i, .bus_grant_i, .bus_req_o, .bus_level_o,
        .bus_busy_o, .posted_tenure_byte_count_i, .sw_bus_hold_bit_i, .dma_tenure_counter_i,
        .as_o, .ds_o, .write_o, .iack_o, .am_o, .addr_o, .dout_o, .dtack_i, .berr_i, .din_i,
        .user_modifier_codes_we_i, .user_modifier_codes_wdata_i, .user_modifier_codes_o, .err_clear_i,
        .vme_error_modifier_log_o, .vme_error_address_log_o, .vme_side_error_irq_enable_i,
        .pci_side_error_irq_enable_i, .irq_vme_o, .irq_pci_o);
    vme_slave_model slave (.mclk_i, .rst_i, .as_i(as_o), .ds_i(ds_o), .fail_i(fail),
        .addr_only_i(lock_valid_i),
        .wait_i(wt), .rdata_i(mdata), .dtack_o(dtack_i), .berr_o(berr_i), .din_o(din_i));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        bus_grant_i <= bus_req_o;
        if (as_o && dtack_i) pq.push_back({am_o, ds_o, dout_o});
        if (as_o) check("bus owned", bus_busy_o, 1'b1);
        n_ab += abort_o;
        n_pu += purge_o;
        n_iv += irq_vme_o;
        n_ip += irq_pci_o;
    end
    function automatic void split(input logic [7:0] be, input int w);
        int i, s;
        expq.delete();
        i = 0;
        while (i < 8) begin
            s = w;
            while (s > 1 && (i % s != 0 || ((be >> i) & ((1 << s) - 1)) != (1 << s) - 1)) s /= 2;
            if (be[i]) expq.push_back(8'(((1 << s) - 1) << i));
            i += be[i] ? s : 1;
        end
    endfunction
    function automatic logic [5:0] am_exp(input req_t r);
        logic [5:0] t;
        t = r.blk ? (r.mblt ? 6'h00 : 6'h03) : (r.prog ? 6'h02 : 6'h01);
        case (r.space)
            SP_A16: return r.sup ? 6'h2D : 6'h29;
            SP_CR: return 6'h2F;
            SP_A24: return 6'h38 + (r.sup ? 6'h04 : 6'h00) + t;
            default: return 6'h08 + (r.sup ? 6'h04 : 6'h00) + t;
        endcase
    endfunction
    task automatic run(input logic [3:0] m);
        int n;
        pq.delete();
        {lock_valid_i, irq_valid_i, dma_valid_i, tgt_valid_i} <= m;
        for (n = 0; n < 400 && take_o == 4'h0 && !abort_o && !purge_o; n++) @(posedge mclk_i);
        if (n == 400) begin
            failures++;
            conclude();
        end
        {lock_valid_i, irq_valid_i, dma_valid_i, tgt_valid_i} <= 4'h0;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic user_write(input logic [1:0] we, input logic [5:0] v);
        user_modifier_codes_we_i <= we;
        user_modifier_codes_wdata_i <= v;
        @(posedge mclk_i);
        user_modifier_codes_we_i <= 2'b00;
        repeat (2) @(posedge mclk_i);
    endtask
    initial begin
        {tgt_valid_i, dma_valid_i, irq_valid_i, lock_valid_i, fail, err_clear_i} = '0;
        {sw_bus_hold_bit_i, vme_side_error_irq_enable_i, pci_side_error_irq_enable_i} = '0;
        {user_modifier_codes_we_i, user_modifier_codes_wdata_i, wt, mdata, beat} = '0;
        req_level_i = 2'h2;
        posted_tenure_byte_count_i = 12'h100;
        dma_tenure_counter_i = 12'h100;
        void'($urandom(86));
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check("codes", user_modifier_codes_o, 12'h410);
        check("log", vme_error_modifier_log_o, 9'h000);
        user_write(2'b01, 6'h1F);
        user_write(2'b10, 6'h20);
        check("codes", user_modifier_codes_o, 12'h41F);
        check("level", bus_level_o, 2'h2);
        for (int k = 0; k < 24; k++) begin
            beat <= '0;
            beat.space <= space_t'(k % 4);
            beat.sup <= $urandom;
            beat.prog <= $urandom;
            beat.blk <= k % 4 > 0 && k % 4 < 3 && $urandom_range(1);
            beat.mblt <= $urandom;
            beat.max_vme_data_width <= width_t'($urandom_range(2));
            beat.be <= (k < 20) ? 8'($urandom_range(15, 1)) : 8'h05;
            beat.addr <= $urandom & 32'hFFFF_FFF8;
            beat.data <= {$urandom, $urandom};
            beat.write <= 1'b1;
            beat.posted <= $urandom;
            wt <= $urandom;
            @(posedge mclk_i);
            split(beat.be, 1 << beat.max_vme_data_width);
            run(4'(k % 2 + 1));
            check("pieces", pq.size(), expq.size());
            foreach (pq[j]) begin
                check("mod", pq[j][77:72], am_exp(beat));
                check("lanes", pq[j][71:64], j < expq.size() ? expq[j] : 8'h00);
                for (int b = 0; b < 8; b++) if (pq[j][64 + b])
                    check("data", pq[j][b*8 +: 8], beat.data[b*8 +: 8]);
            end
        end
        beat.be <= 8'h0F;
        beat.max_vme_data_width <= W32;
        beat.write <= 1'b0;
        beat.blk <= 1'b0;
        mdata <= {$urandom, $urandom};
        run(4'h1);
        check("read", rdata_o[31:0], mdata[31:0]);
        fail <= 1'b1;
        beat.write <= 1'b1;
        beat.posted <= 1'b1;
        vme_side_error_irq_enable_i <= 1'b1;
        run(4'h1);
        check("log", vme_error_modifier_log_o, {3'b100, am_exp(beat)});
        check("addr", vme_error_address_log_o, beat.addr);
        check("purge", n_pu, 64'd1);
        check("irq", {n_iv, n_ip}, {32'd1, 32'd0});
        vme_side_error_irq_enable_i <= 1'b0;
        pci_side_error_irq_enable_i <= 1'b1;
        run(4'h2);
        check("multi", vme_error_modifier_log_o.multi, 1'b1);
        check("irq", {n_iv, n_ip}, {32'd1, 32'd1});
        beat.posted <= 1'b0;
        beat.write <= 1'b0;
        run(4'h1);
        check("abort", {n_ab, n_pu}, {32'd1, 32'd2});
        check("addr", vme_error_address_log_o, beat.addr);
        err_clear_i <= 1'b1;
        beat.iack <= 1'b1;
        @(posedge mclk_i);
        err_clear_i <= 1'b0;
        run(4'h4);
        check("iack log", vme_error_modifier_log_o, {3'b101, am_exp(beat)});
        fail <= 1'b0;
        beat.iack <= 1'b0;
        beat.user <= 2'h1;
        beat.space <= SP_A32;
        run(4'h1);
        check("user", pq[0][77:72], 6'h1F);
        beat.space <= SP_A24;
        run(4'h8);
        check("lock", pq[0][77:64], {6'h32, 8'h00});
        conclude();
    end
endmodule // tb_vme_master_interface
`default_nettype wire
